//--- scgc_pkg.sv
// Package for the sleep clock-gate control block: offsets, fields, resets
package scgc_pkg;
  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] SCGC_RUN_OFF = 12'h104;
  localparam logic [11:0] SCGC_SLEEP_OFF = 12'h114;
  localparam logic [11:0] SCGC_DEEP_OFF = 12'h124;
  localparam logic [11:0] SCGC_CFG_OFF = 12'h060;
  localparam logic [11:0] SCGC_ISTAT_OFF = 12'h200;
  localparam logic [11:0] SCGC_IMASK_OFF = 12'h204;
  // ------------------------------------------------------------------
  // Field layout of the gate registers
  // ------------------------------------------------------------------
  localparam int SCGC_CMP2_BIT = 26;
  localparam int SCGC_CMP1_BIT = 25;
  localparam int SCGC_CMP0_BIT = 24;
  localparam int SCGC_GPTMR3_BIT = 19;
  localparam int SCGC_GPTMR2_BIT = 18;
  localparam int SCGC_GPTMR1_BIT = 17;
  localparam int SCGC_GPTMR0_BIT = 16;
  localparam int SCGC_SYNC0_BIT = 4;
  localparam int SCGC_ASER1_BIT = 1;
  localparam int SCGC_ASER0_BIT = 0;
  localparam logic [31:0] SCGC_GATE_MASK = 32'h070F0013;
  localparam logic [31:0] SCGC_GATE_RST = 32'h00000000;
  // Config register: auto gating select bit
  localparam int SCGC_AUTO_GATE_BIT = 27;
  localparam logic [31:0] SCGC_CFG_MASK = 32'h08000000;
  localparam logic [31:0] SCGC_CFG_RST = 32'h00000000;
  // Interrupt status: fault per unit in gate layout
  localparam logic [31:0] SCGC_INT_RST = 32'h00000000;
  // ------------------------------------------------------------------
  // Power modes and AXI responses
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCGC_MODE_RUN = 2'h0,
    SCGC_MODE_SLEEP = 2'h1,
    SCGC_MODE_DEEP = 2'h3
  } scgc_mode_t;
  localparam logic [1:0] SCGC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCGC_RESP_SLVERR = 2'h2;
endpackage : scgc_pkg

//--- scgc_sleep_gate.sv
// Sleep-mode clock gate control register block with AXI4-Lite slave
//
// Functional notes
// - Each implemented bit enables one unit's clock; zero stops and disables it.
// - Access to a unit with clock gated off answers with a bus fault.
// - Reset clears every enable bit so all units start unclocked.
// - Separate run, sleep and deep-sleep enable sets are kept.
// - Sleep sets govern clocks only when auto gating select is set.
// - Bits 26, 25, 24 gate comparators 2, 1, 0.
// - Bits 19 to 16 gate general-purpose timers 3 to 0.
// - Bit 4 gates synchronous serial module 0.
// - Bits 1 and 0 gate asynchronous serial modules 1 and 0.
// - Reserved ranges are read-only, read zero; software preserves them.
`timescale 1ns/10ps
`default_nettype none

module scgc_sleep_gate (
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic [1:0] power_mode, // Current power mode (scgc_mode_t code)
  input wire logic [31:0] unit_access, // One-cycle access strobe per unit bit
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] unit_clk_en, // Active clock enable per unit
  output logic [31:0] unit_fault, // One-cycle bus fault per unit
  output logic irq // Level interrupt, unmasked fault pending
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Byte-lane merge limited to writable bits
  // Reserved bits never reach a flop, so no write can set them
  function automatic logic [31:0] scgc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb,
                                             input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction : scgc_merge

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0] run_q, run_d;
  logic [31:0] sleep_q, sleep_d;
  logic [31:0] deep_q, deep_d;
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] istat_q, istat_d;
  logic [31:0] imask_q, imask_d;
  logic [31:0] gate_q, gate_d;
  logic [31:0] fault_q, fault_d;
  logic irq_q, irq_d;
  logic [2:0] mode_sync_q, mode_sync_d;
  logic [2:0] mode_hi_q, mode_hi_d;
  logic [1:0] mode_q, mode_d;
  logic aw_q, aw_d;
  logic w_q, w_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic arready_q, arready_d;

  logic aw_take, w_take, ar_take, wr_go;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  // ------------------------------------------------------------------
  // Handshake terms
  // ------------------------------------------------------------------
  // Ready is registered, so a take needs a ready already high
  // Limitation: readies are not gated by clk_en, so the master must be
  // frozen by the same enable, or a beat offered while it is low is lost
  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign ar_take = s_axi_arvalid && arready_q;
  assign wa = aw_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_q ? wdata_q : s_axi_wdata;
  assign ws = w_q ? wstrb_q : s_axi_wstrb;
  assign wr_go = (aw_q || aw_take) && (w_q || w_take) && !bvalid_q;

  // Power mode pin crossing: three flops, accept when last two agree
  // A pin moving between edges costs a cycle, never a wrong mode
  always_comb begin
    mode_sync_d = {mode_sync_q[1:0], power_mode[0]};
    mode_hi_d = {mode_hi_q[1:0], power_mode[1]};
    mode_d = mode_q;
    if (mode_sync_q[2] == mode_sync_q[1] && mode_hi_q[2] == mode_hi_q[1]) begin
      mode_d = {mode_hi_q[2], mode_sync_q[2]};
    end
  end

  // ------------------------------------------------------------------
  // AXI write and read channels, register updates
  // ------------------------------------------------------------------
  // Write address and data may arrive in either order; response after both
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    run_d = run_q;
    sleep_d = sleep_q;
    deep_d = deep_q;
    cfg_d = cfg_q;
    imask_d = imask_q;
    istat_d = istat_q;
    if (aw_take) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (w_take) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = scgc_pkg::SCGC_RESP_OKAY;
      // Writes to the status register are ignored but still answered OKAY
      case (wa)
        scgc_pkg::SCGC_RUN_OFF: run_d = scgc_merge(run_q, wd, ws, scgc_pkg::SCGC_GATE_MASK);
        scgc_pkg::SCGC_SLEEP_OFF: begin
          sleep_d = scgc_merge(sleep_q, wd, ws, scgc_pkg::SCGC_GATE_MASK);
        end
        scgc_pkg::SCGC_DEEP_OFF: deep_d = scgc_merge(deep_q, wd, ws, scgc_pkg::SCGC_GATE_MASK);
        scgc_pkg::SCGC_CFG_OFF: cfg_d = scgc_merge(cfg_q, wd, ws, scgc_pkg::SCGC_CFG_MASK);
        scgc_pkg::SCGC_IMASK_OFF: imask_d = scgc_merge(imask_q, wd, ws, scgc_pkg::SCGC_GATE_MASK);
        scgc_pkg::SCGC_ISTAT_OFF: bresp_d = scgc_pkg::SCGC_RESP_OKAY;
        default: bresp_d = scgc_pkg::SCGC_RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // Reading status clears it; reserved bits read zero
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = scgc_pkg::SCGC_RESP_OKAY;
      case (s_axi_araddr)
        scgc_pkg::SCGC_RUN_OFF: rdata_d = run_q;
        scgc_pkg::SCGC_SLEEP_OFF: rdata_d = sleep_q & scgc_pkg::SCGC_GATE_MASK;
        scgc_pkg::SCGC_DEEP_OFF: rdata_d = deep_q;
        scgc_pkg::SCGC_CFG_OFF: rdata_d = cfg_q;
        scgc_pkg::SCGC_IMASK_OFF: rdata_d = imask_q;
        scgc_pkg::SCGC_ISTAT_OFF: begin
          rdata_d = istat_q;
          istat_d = 32'h00000000;
        end
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = scgc_pkg::SCGC_RESP_SLVERR;
        end
      endcase
    end
    // New faults win over the read clear
    // so an event in the read cycle is kept for the next read
    istat_d = istat_d | fault_q;
  end

  // Ready drops while a beat is held or an answer is pending
  always_comb begin
    awready_d = !aw_d && !bvalid_d;
    wready_d = !w_d && !bvalid_d;
    arready_d = !rvalid_d && !ar_take;
  end

  // ------------------------------------------------------------------
  // Clock gate selection and fault detection
  // ------------------------------------------------------------------
  // Sleep sets apply only with auto gating on; run set otherwise
  // Mode code 2 is no documented mode and falls back to the run set
  always_comb begin
    gate_d = run_q;
    if (cfg_q[scgc_pkg::SCGC_AUTO_GATE_BIT]) begin
      if (mode_q == scgc_pkg::SCGC_MODE_SLEEP) begin
        gate_d = sleep_q;
      end else if (mode_q == scgc_pkg::SCGC_MODE_DEEP) begin
        gate_d = deep_q;
      end
    end
    gate_d = gate_d & scgc_pkg::SCGC_GATE_MASK;
    // Faults use the gate already in force; an access in the cycle that
    // turns its unit on still faults, keeping the path one flop deep
    fault_d = unit_access & ~gate_q & scgc_pkg::SCGC_GATE_MASK;
    irq_d = |(istat_d & imask_q);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // All enables start at zero so units wake up unclocked
  // Everything freezes while clk_en is low; a bus beat offered then is lost, since the readies stay high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= scgc_pkg::SCGC_GATE_RST;
      sleep_q <= scgc_pkg::SCGC_GATE_RST;
      deep_q <= scgc_pkg::SCGC_GATE_RST;
      cfg_q <= scgc_pkg::SCGC_CFG_RST;
      istat_q <= scgc_pkg::SCGC_INT_RST;
      imask_q <= scgc_pkg::SCGC_INT_RST;
      gate_q <= scgc_pkg::SCGC_GATE_RST;
      fault_q <= scgc_pkg::SCGC_INT_RST;
      irq_q <= 1'b0;
      mode_sync_q <= 3'h0;
      mode_hi_q <= 3'h0;
      mode_q <= 2'h0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else if (clk_en) begin
      run_q <= run_d;
      sleep_q <= sleep_d;
      deep_q <= deep_d;
      cfg_q <= cfg_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      gate_q <= gate_d;
      fault_q <= fault_d;
      irq_q <= irq_d;
      mode_sync_q <= mode_sync_d;
      mode_hi_q <= mode_hi_d;
      mode_q <= mode_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  // Outputs straight from flops
  // No logic between these flops and the pins, so timing stays local
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign unit_clk_en = gate_q;
  assign unit_fault = fault_q;
  assign irq = irq_q;

endmodule : scgc_sleep_gate

`default_nettype wire

//--- scgc_sleep_gate_props.sv
// Port assertions for the sleep clock-gate block
`timescale 1ns/10ps
`default_nettype none
module scgc_sleep_gate_props (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic clk_en, // Run enable
  input wire logic [31:0] unit_access, // Unit strobes
  input wire logic [31:0] unit_clk_en, // Active gates
  input wire logic [31:0] unit_fault, // Fault pulses
  input wire logic irq, // Interrupt
  input wire logic s_axi_bvalid, // B valid
  input wire logic [11:0] s_axi_araddr, // AR addr
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic s_axi_rvalid // R valid
);
  // ----------------------------------------------
  // Relations between ports
  // ----------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic ar_take;
  // Read address taken; frozen cycles do not count
  assign ar_take = s_axi_arvalid && s_axi_arready && clk_en;
  a_reset_clear: assert property ($rose(rst_n) |-> unit_clk_en == 32'h0 && !irq)
    else $error("gate or irq set after reset");
  a_fault_gated: assert property (clk_en |=> unit_fault ==
    ($past(unit_access) & ~$past(unit_clk_en) & scgc_pkg::SCGC_GATE_MASK))
    else $error("fault does not match gated access");
  a_gate_rsv: assert property ((unit_clk_en & ~scgc_pkg::SCGC_GATE_MASK) == 32'h0)
    else $error("gate set on reserved bit");
  a_sleep_rsv_rd: assert property (ar_take && s_axi_araddr == 12'h114 |=>
    (s_axi_rdata & ~scgc_pkg::SCGC_GATE_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  a_sets_okay: assert property (ar_take && (s_axi_araddr == 12'h104 ||
    s_axi_araddr == 12'h124) |=> s_axi_rresp == scgc_pkg::SCGC_RESP_OKAY)
    else $error("gate set not readable");
  a_unmapped_err: assert property (ar_take && s_axi_araddr == 12'h008 |=>
    s_axi_rresp == scgc_pkg::SCGC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_latency: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_irq_cause: assert property ($rose(irq) |->
    $past(unit_fault, 2) != 32'h0 || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("irq rose without cause");
endmodule : scgc_sleep_gate_props
`default_nettype wire

//--- test_scgc_sleep_gate.sv
// Self-checking bench for the sleep clock-gate block
`timescale 1ns/10ps
`default_nettype none
module test_scgc_sleep_gate;
  localparam logic [11:0] SLP = 12'h114;
  localparam logic [11:0] IST = 12'h200;
  logic clk, rst_n, awv, wv, bv, brdy, arv, rv, rrdy, awr, wr, arr, irq;
  logic [1:0] mode, bresp, rresp;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, ua, gate, fault;
  int n_errors, checked;
  // Byte strobes and run enable stay fixed; the gate logic is the target
  scgc_sleep_gate dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .power_mode(mode),
    .unit_access(ua), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .unit_clk_en(gate), .unit_fault(fault), .irq(irq));
  // ----------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Waits for the answer however long it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv);
    brdy <= 1'b0;
    chk("bresp", {30'h0, bresp}, 32'h0);
  endtask : axi_wr
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rrdy <= 1'b0;
    chk(nm, rd, exp);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask : rd_chk
  // Mode pin crosses three sync flops, then the mode and gate flops, so six cycles suffice
  task automatic gate_chk(input logic [1:0] m, input logic [31:0] exp);
    @(posedge clk);
    mode <= m;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("gate", gate, exp);
  endtask : gate_chk
  // ----------------------------------------------
  // Scenarios
  // ----------------------------------------------
  task automatic t_reset();
    rd_chk("sleep", SLP, 32'h0, 2'h0);
    rd_chk("run", 12'h104, 32'h0, 2'h0);
    rd_chk("deep", 12'h124, 32'h0, 2'h0);
    gate_chk(2'h0, 32'h0);
  endtask : t_reset
  task automatic t_fields();
    axi_wr(SLP, 32'hFFFFFFFF);
    rd_chk("sleep_all", SLP, 32'h070F0013, 2'h0);
    axi_wr(SLP, 32'hF8F0FFEC);
    rd_chk("sleep_rsv", SLP, 32'h0, 2'h0);
  endtask : t_fields
  task automatic t_select();
    axi_wr(12'h104, 32'h00000001);
    axi_wr(SLP, 32'h00000010);
    axi_wr(12'h124, 32'h04000000);
    gate_chk(2'h1, 32'h1);
    axi_wr(12'h060, 32'h08000000);
    gate_chk(2'h1, 32'h10);
    gate_chk(2'h3, 32'h04000000);
    gate_chk(2'h0, 32'h1);
  endtask : t_select
  // Unit 0 is clocked and unit 16 is not; only the latter may fault
  task automatic t_fault();
    @(posedge clk);
    ua <= 32'h00010001;
    @(posedge clk);
    ua <= 32'h0;
    @(negedge clk);
    chk("fault", fault, 32'h00010000);
    repeat (4) @(posedge clk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    axi_wr(12'h204, 32'h00010000);
    repeat (4) @(posedge clk);
    chk("irq_set", {31'h0, irq}, 32'h1);
    rd_chk("status", IST, 32'h00010000, 2'h0);
    repeat (4) @(posedge clk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    rd_chk("status_clr", IST, 32'h0, 2'h0);
    rd_chk("unmapped", 12'h008, 32'h0, 2'h2);
  endtask : t_fault
  // Reset in mid-run must clear sets that software had turned on
  task automatic t_rerst();
    axi_wr(SLP, 32'h00000010);
    axi_wr(12'h104, 32'h00010001);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("gate_rst", gate, 32'h0);
    rd_chk("sleep_rst", SLP, 32'h0, 2'h0);
    rd_chk("run_rst", 12'h104, 32'h0, 2'h0);
  endtask : t_rerst
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Main sequence
  initial begin
    {rst_n, awv, wv, brdy, arv, rrdy} = '0;
    {awa, ara, mode} = '0;
    {wd, ua} = '0;
    n_errors = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_select();
    t_fault();
    t_rerst();
    finish_test();
  end
  // Watchdog well past the hundred or so cycles the run needs
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
endmodule : test_scgc_sleep_gate
bind scgc_sleep_gate scgc_sleep_gate_props u_props (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault), .irq(irq),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire
